// File: rtl/srg_pkg.sv
package srg_pkg;

  // ==========================================================
  // Timebase
  // ==========================================================
  localparam int unsigned CLK_PERIOD_PS = 20000;

  // ==========================================================
  // Release delay options (least times, rounded up)
  // ==========================================================
  localparam int unsigned DLY_SHORT_US  = 1090;
  localparam int unsigned DLY_MID_US    = 17500;
  localparam int unsigned DLY_LONG_US   = 140000;
  localparam int unsigned TYP_LONG_MS   = 280;
  localparam int unsigned DLY_SHORT_CYC = (DLY_SHORT_US * 1000 + 19) / 20;
  localparam int unsigned DLY_MID_CYC   = (DLY_MID_US * 1000 + 19) / 20;
  localparam int unsigned DLY_LONG_CYC  = (DLY_LONG_US * 1000 + 19) / 20;

  // ==========================================================
  // Manual reset filter, assert bound and counter widths
  // ==========================================================
  localparam int unsigned FILT_NS       = 100;
  localparam int unsigned FILT_CYC      = (FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ASSERT_MAX_US = 50;
  localparam int unsigned ASSERT_MAX_CYC = ASSERT_MAX_US * 1000000 / CLK_PERIOD_PS;

  localparam int unsigned CNT_W  = 24;
  localparam int unsigned FCNT_W = 4;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 24'h00_0000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 24'h00_0001;
  localparam logic [FCNT_W-1:0] FCNT_ZERO = 4'h0;
  localparam logic [FCNT_W-1:0] FCNT_ONE  = 4'h1;

  // ==========================================================
  // Build options and state encoding
  // ==========================================================
  typedef enum logic [1:0] {
    SRG_DLY_SHORT = 2'h0,
    SRG_DLY_MID   = 2'h1,
    SRG_DLY_LONG  = 2'h2
  } srg_dly_type;

  typedef enum logic [1:0] {
    SRG_PP_LOW  = 2'h0,
    SRG_OD_LOW  = 2'h1,
    SRG_PP_HIGH = 2'h2
  } srg_variant_type;

  typedef enum logic [2:0] {
    SRG_ST_HOLD  = 3'b001,
    SRG_ST_DELAY = 3'b010,
    SRG_ST_RUN   = 3'b100
  } srg_state_type;

endpackage

// File: rtl/srg_reset_gen.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Push-pull low variant: low while undervoltage
// - Push-pull low: hold low delay, then high
// - Push-pull high variant: high while undervoltage
// - Push-pull high: hold high delay, then low
// - Open-drain: sink low active, float after delay
// - Manual input active low, pulled up idle
// - Manual input filtered against short spikes
// - Reset active at power-up, undervoltage, manual
// - Three delay options: 1.09, 17.5, 140 ms
// - Polarity option: one high, two low
// - Driver option: two push-pull, one open-drain
// - Undervoltage flag follows comparator trip limits
// - Rising supply releases only after full delay
// - Assert within 50 us of crossing
// - Delay completes before output goes inactive
// - Start in reset, run once supply valid
// - Reject manual pulses shorter than 100 ns
// - Timer starts only with both sources inactive
// - Any source active again clears timer
module srg_reset_gen
  import srg_pkg::*;
#(
  parameter srg_dly_type     DLY_SEL  = SRG_DLY_LONG,
  parameter srg_variant_type VARIANT  = SRG_PP_LOW,
  parameter int unsigned     DLY_SHORT = DLY_SHORT_CYC,
  parameter int unsigned     DLY_MID   = DLY_MID_CYC,
  parameter int unsigned     DLY_LONG  = DLY_LONG_CYC
)(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic under_volt,
  input  wire logic manual_reset_in_n,
  output logic      rst_out,
  output logic      rst_out_oe,
  output logic      rst_active
);

  // ==========================================================
  // Terminal count for the selected delay
  // ==========================================================
  function automatic logic [CNT_W-1:0] dly_term(input srg_dly_type s);
    case (s)
      SRG_DLY_SHORT: dly_term = CNT_W'(DLY_SHORT);
      SRG_DLY_MID:   dly_term = CNT_W'(DLY_MID);
      default:       dly_term = CNT_W'(DLY_LONG);
    endcase
  endfunction

  localparam logic [CNT_W-1:0]  TERM  = dly_term(DLY_SEL);
  localparam logic [FCNT_W-1:0] FTERM = FCNT_W'(FILT_CYC);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic               uv_s1;
    logic               uv_s2;
    logic               mr_s1;
    logic               mr_s2;
    logic               mr_filt;
    logic [FCNT_W-1:0]  fcnt;
    logic [CNT_W-1:0]   cnt;
    srg_state_type      st;
    logic               act;
  } srg_regs_type;

  srg_regs_type state_r;
  srg_regs_type state_nxt;
  logic         uv_async;
  logic         src_act;

  // Comparator hysteresis lives in the analog front end; flag taken as is
  assign uv_async = under_volt;

  always_comb
  begin
    state_nxt = state_r;
    // Two-flop synchronisers
    state_nxt.uv_s1 = uv_async;
    state_nxt.uv_s2 = state_r.uv_s1;
    // Undriven pin reads high through the pad pull-up
    state_nxt.mr_s1 = ~manual_reset_in_n;
    state_nxt.mr_s2 = state_r.mr_s1;
    // Low level must persist FTERM cycles to count
    if (!state_r.mr_s2)
    begin
      state_nxt.fcnt    = FCNT_ZERO;
      state_nxt.mr_filt = 1'b0;
    end
    else if (state_r.fcnt >= FTERM - FCNT_ONE)
    begin
      state_nxt.mr_filt = 1'b1;
    end
    else
    begin
      state_nxt.fcnt = state_r.fcnt + FCNT_ONE;
    end
    src_act = state_r.uv_s2 | state_r.mr_filt;
    case (state_r.st)
      SRG_ST_HOLD:
      begin
        state_nxt.cnt = CNT_ZERO;
        state_nxt.act = 1'b1;
        if (!src_act)
        begin
          state_nxt.st = SRG_ST_DELAY;
        end
      end
      SRG_ST_DELAY:
      begin
        state_nxt.act = 1'b1;
        if (src_act)
        begin
          state_nxt.cnt = CNT_ZERO;
          state_nxt.st  = SRG_ST_HOLD;
        end
        else if (state_r.cnt >= TERM - CNT_ONE)
        begin
          state_nxt.act = 1'b0;
          state_nxt.st  = SRG_ST_RUN;
        end
        else
        begin
          state_nxt.cnt = state_r.cnt + CNT_ONE;
        end
      end
      SRG_ST_RUN:
      begin
        state_nxt.act = 1'b0;
        if (src_act)
        begin
          state_nxt.act = 1'b1;
          state_nxt.cnt = CNT_ZERO;
          state_nxt.st  = SRG_ST_HOLD;
        end
      end
      default:
      begin
        state_nxt.st  = SRG_ST_HOLD;
        state_nxt.act = 1'b1;
      end
    endcase
  end

  // Reset loads a pessimistic picture: under-volt seen, held in reset
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r.uv_s1   <= 1'b1;
      state_r.uv_s2   <= 1'b1;
      state_r.mr_s1   <= 1'b0;
      state_r.mr_s2   <= 1'b0;
      state_r.mr_filt <= 1'b0;
      state_r.fcnt    <= FCNT_ZERO;
      state_r.cnt     <= CNT_ZERO;
      state_r.st      <= SRG_ST_HOLD;
      state_r.act     <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Output stage
  // ==========================================================
  // Async undervoltage bypass keeps assertion immediate
  assign rst_active = state_r.act | uv_async | ~rst_n;

  always_comb
  begin
    case (VARIANT)
      SRG_PP_HIGH:
      begin
        rst_out    = rst_active;
        rst_out_oe = 1'b1;
      end
      SRG_OD_LOW:
      begin
        rst_out    = 1'b0;
        rst_out_oe = rst_active;
      end
      default:
      begin
        rst_out    = ~rst_active;
        rst_out_oe = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence uv_held_s;
    state_r.uv_s2 ##1 !state_r.uv_s2;
  endsequence

  // Three samples cover both synchroniser stages
  sequence uv_seen_s;
    under_volt [*3];
  endsequence

  // Five pressed cycles are the whole filter length
  sequence mr_held_s;
    state_r.mr_s2 [*5];
  endsequence

  sequence delay_hit_s;
    state_r.st == SRG_ST_DELAY && src_act;
  endsequence

  sequence sources_clear_s;
    state_r.st == SRG_ST_HOLD && !src_act;
  endsequence

  property no_early_release_p;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r.st == SRG_ST_DELAY) |-> rst_active;
  endproperty

  // ==========================================================
  // Checks: sequencing
  // ==========================================================
  uv_forces_active_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n) under_volt |-> rst_active)
    else $error("Reset not active under undervoltage");
  delay_holds_a: assert property (no_early_release_p)
    else $error("Released during delay");
  release_after_term_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(state_r.act) |-> $past(state_r.cnt) >= TERM - CNT_ONE)
    else $error("Release before delay expired");
  restart_clears_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r.st == SRG_ST_DELAY && src_act) |=> state_r.cnt == CNT_ZERO)
    else $error("Timer not cleared on new source");
  start_gate_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r.st == SRG_ST_HOLD && src_act) |=> state_r.st == SRG_ST_HOLD)
    else $error("Timer started with active source");
  recover_seq_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    uv_held_s |-> rst_active)
    else $error("Reset dropped on recovery");
  delay_restart_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    delay_hit_s |=> (state_r.st == SRG_ST_HOLD && state_r.act))
    else $error("Delay not abandoned on new source");
  timer_start_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    sources_clear_s |=> (state_r.st == SRG_ST_DELAY && state_r.cnt == CNT_ZERO))
    else $error("Timer not started from zero");
  hold_active_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r.st == SRG_ST_HOLD) |-> state_r.act)
    else $error("Hold state without active reset");
  run_inactive_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r.st == SRG_ST_RUN) |-> !state_r.act)
    else $error("Run state with reset still active");
  count_bound_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r.st == SRG_ST_DELAY) |-> state_r.cnt <= TERM - CNT_ONE)
    else $error("Delay counter past terminal count");
  state_onehot_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $onehot(state_r.st))
    else $error("State code not one-hot");

  // ==========================================================
  // Checks: input paths
  // ==========================================================
  uv_sync_path_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    uv_seen_s |=> state_r.act)
    else $error("Synchronised undervoltage not registered");
  short_mr_ignored_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(state_r.mr_s2) |-> (!state_r.mr_filt) [*5])
    else $error("Short manual pulse passed");
  mr_filter_pass_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mr_held_s |=> state_r.mr_filt)
    else $error("Held manual press not passed");
  mr_clears_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !state_r.mr_s2 |=> (!state_r.mr_filt && state_r.fcnt == FCNT_ZERO))
    else $error("Manual filter not cleared on release");
  mr_asserts_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    state_r.mr_filt |=> rst_active)
    else $error("Manual reset not asserted");

  // ==========================================================
  // Checks: output stage
  // ==========================================================
  pol_od_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (VARIANT == SRG_OD_LOW) |-> (rst_out == 1'b0 && rst_out_oe == rst_active))
    else $error("Open-drain drive wrong");
  pol_pp_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (VARIANT == SRG_PP_LOW) |-> (rst_out_oe && rst_out == !rst_active))
    else $error("Active-low push-pull wrong");
  pol_hi_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (VARIANT == SRG_PP_HIGH) |-> (rst_out_oe && rst_out == rst_active))
    else $error("Active-high push-pull wrong");

endmodule // srg_reset_gen

// File: verif/srg_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host reset pin and push button
// ==========================================================
module srg_host_model (
  input  wire logic rst_out,
  input  wire logic rst_out_oe,
  input  wire logic press,
  output logic      host_rst_n,
  output logic      manual_reset_in_n
);
  // Board pull-up wins once the pin is released
  assign host_rst_n = rst_out_oe ? rst_out : 1'b1;
  // Open switch idles high, pressed shorts to ground
  assign manual_reset_in_n = press ? 1'b0 : 1'b1;
endmodule // srg_host_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import srg_pkg::*;
  // ==========================================================
  // Clock, reset, instances
  // ==========================================================
  // Short delays keep the run brief; unselected options keep defaults
  localparam int SIM_SHORT = 10;
  localparam int SIM_MID   = 20;
  localparam int SIM_LONG  = 30;
  int         term [3] = '{SIM_SHORT, SIM_MID, SIM_LONG};
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       under_volt = 1'b1;
  logic       press = 1'b0;
  logic       mr_n;
  logic       host_rst_n;
  wire  [2:0] act;
  wire  [2:0] pin;
  wire  [2:0] oe;
  int         n_fail = 0;
  int         n_tests = 0;
  int         cyc = 0;

  always #10 clk_sys = ~clk_sys;

  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      complete_run();
    end
  end

  srg_reset_gen #(.DLY_SEL(SRG_DLY_SHORT), .VARIANT(SRG_PP_LOW), .DLY_SHORT(SIM_SHORT))
    i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .under_volt(under_volt),
    .manual_reset_in_n(mr_n), .rst_out(pin[0]), .rst_out_oe(oe[0]), .rst_active(act[0]));
  srg_reset_gen #(.DLY_SEL(SRG_DLY_MID), .VARIANT(SRG_OD_LOW), .DLY_MID(SIM_MID))
    i_dut_od (.clk_sys(clk_sys), .rst_n(rst_n), .under_volt(under_volt),
    .manual_reset_in_n(mr_n), .rst_out(pin[1]), .rst_out_oe(oe[1]), .rst_active(act[1]));
  srg_reset_gen #(.DLY_SEL(SRG_DLY_LONG), .VARIANT(SRG_PP_HIGH), .DLY_LONG(SIM_LONG))
    i_dut_hi (.clk_sys(clk_sys), .rst_n(rst_n), .under_volt(under_volt),
    .manual_reset_in_n(mr_n), .rst_out(pin[2]), .rst_out_oe(oe[2]), .rst_active(act[2]));
  srg_host_model i_host (.rst_out(pin[1]), .rst_out_oe(oe[1]), .press(press),
    .host_rst_n(host_rst_n), .manual_reset_in_n(mr_n));

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(string nm, logic [2:0] e, logic [2:0] g);
    n_tests++;
    if (e !== g)
    begin
      n_fail++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_out(logic [2:0] e);
    chk("active", e, act);
    chk("pins", {e[2], 1'b0, ~e[0]}, pin);
    chk("enables", {1'b1, e[1], 1'b1}, oe);
    chk("host pin", {2'b00, ~e[1]}, {2'b00, host_rst_n});
  endtask

  task automatic step(int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Slack covers the filter release path of the manual input
  task automatic time_rel(int slack);
    int         c [3];
    logic [2:0] ok;
    c = '{0, 0, 0};
    for (int i = 1; i <= 60; i++)
    begin
      @(negedge clk_sys);
      for (int k = 0; k < 3; k++)
        if (act[k] !== 1'b1 && c[k] == 0) c[k] = i;
    end
    for (int k = 0; k < 3; k++)
      ok[k] = c[k] >= term[k] + 2 && c[k] <= term[k] + 5 + slack;
    chk("release delay", 3'b111, ok);
    chk_out(3'b000);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_power_up();
    step(10);
    chk_out(3'b111);
    under_volt = 1'b0;
    time_rel(0);
    $display("test power_up done");
  endtask

  task automatic t_glitch();
    press = 1'b1;
    step(4);
    press = 1'b0;
    step(20);
    chk_out(3'b000);
    $display("test glitch done");
  endtask

  task automatic t_manual();
    press = 1'b1;
    step(12);
    chk_out(3'b111);
    press = 1'b0;
    time_rel(8);
    $display("test manual done");
  endtask

  task automatic t_restart();
    under_volt = 1'b1;
    #1 chk_out(3'b111);
    step(3);
    under_volt = 1'b0;
    step(8);
    under_volt = 1'b1;
    #1 chk_out(3'b111);
    step(2);
    under_volt = 1'b0;
    time_rel(0);
    $display("test restart done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    step(2);
    chk_out(3'b111);
    step(2);
    rst_n = 1'b1;
    t_power_up();
    t_glitch();
    t_manual();
    t_restart();
    complete_run();
  end
endmodule // tb_top
